// *** hdl/drs_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Overview of operation
// - Alarm match of running count against alarm value raises the interrupt.
// - Trim adds signed correction to the count every programmed interval.
// - Seconds counter divides 32768 Hz to 1 Hz, counts whole seconds.
// - Flexible counter prescales by two to the power 0..15.
// - Flexible counter runs from crystal or internal oscillator; seconds from crystal.
// - Flexible alarm resolves to one 32 kHz source cycle.
// - Seconds alarm is single, absolute, fires once.
// - Flexible counter has absolute alarm plus periodic alarm every 60 units.
// - Four strobe channels, programmable period and duty; three reach pins.
// - Strobe pulse starts when the running count reaches its target.
// - Strobes run in active, flexi, hibernate; stopped in shutdown.
// - Selected capture input transition latches the source-cycle count.
// - Capture raises wake and interrupt; latched value stays readable.
// - Each channel samples up to three sense inputs at strobe end.
// - Each channel may interrupt on activity of its sampled inputs.
// ---------------------------------------------------------------------------
module drs_top (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic [drs_pkg::ADDR_W-1:0] addr,
	input  wire logic [drs_pkg::DATA_W-1:0] wdata,
	input  wire logic                      wr,
	input  wire logic                      rd,
	output logic      [drs_pkg::DATA_W-1:0] rdata,
	input  wire logic                      lf_crystal_clock,
	input  wire logic                      lf_internal_osc,
	input  wire logic [drs_pkg::NUM_CAP-1:0] capture_in,
	input  wire logic [drs_pkg::NUM_STB*drs_pkg::NUM_SMP-1:0] sense_in,
	output logic                           strobe_out_1,
	output logic                           strobe_out_2,
	output logic                           strobe_out_3,
	output logic                           irq,
	output logic                           wake
);
	import drs_pkg::*;

	drs_ctrl_t    ctrl, next_ctrl;
	drs_trim_t    trim, next_trim;
	logic [14:0]  sec_div, next_sec_div;
	logic [31:0]  sec_count, next_sec_count;
	logic [31:0]  sec_alarm, next_sec_alarm;
	logic [31:0]  flx_cyc, next_flx_cyc;
	logic [31:0]  flx_alarm, next_flx_alarm;
	logic [31:0]  cap_val, next_cap_val;
	logic [5:0]   per_cnt, next_per_cnt;
	logic [7:0]   trim_cnt, next_trim_cnt;
	logic [ST_W-1:0] stat, next_stat;
	logic [ST_W-1:0] st_set, st_clr, irq_mask;
	logic [31:0]  stb_tgt [NUM_STB];
	logic [31:0]  next_stb_tgt [NUM_STB];
	drs_stb_cfg_t stb_cfg [NUM_STB];
	drs_stb_cfg_t next_stb_cfg [NUM_STB];
	drs_smp_cfg_t smp_cfg [NUM_STB];
	drs_smp_cfg_t next_smp_cfg [NUM_STB];
	logic [NUM_SMP-1:0] smp_val [NUM_STB];
	logic [31:0]  next_rdata;
	logic         next_irq, next_wake;

	logic [SYNC_W-1:0]  sy_q, sy_chg;
	logic [NUM_CAP-1:0] cap_chg;
	logic [NUM_STB-1:0] stb_pin, stb_act;
	logic [31:0]  unit_mask, flx_units, corr_ext;
	logic         xtal_rise, osc_rise, flx_tick, flx_run;
	logic         sec_tick, unit_tick, trim_hit, sec_hit, flx_hit, cap_hit, shutdown;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ---------------------------------------------------------------------------
	// Pin synchronisation
	// ---------------------------------------------------------------------------
	drs_sync #(
		.W   (SYNC_W)
	) u_sync (
		.clk (clk),
		.rst_n (rst_n),
		.d   ({sense_in, capture_in, lf_internal_osc, lf_crystal_clock}),
		.q   (sy_q),
		.chg (sy_chg)
	);

	// Source ticks and event decode
	assign xtal_rise = sy_chg[SY_XTAL] & sy_q[SY_XTAL];
	assign osc_rise  = sy_chg[SY_OSC] & sy_q[SY_OSC];
	assign flx_tick  = ctrl.lf_sel ? osc_rise : xtal_rise;
	assign flx_run   = ctrl.flx_en & flx_tick;
	assign sec_tick  = ctrl.sec_en & xtal_rise & (sec_div == SEC_DIV_LAST);
	assign unit_mask = ~(32'hFFFFFFFF << ctrl.presc);
	assign flx_units = flx_cyc >> ctrl.presc;
	assign unit_tick = flx_run & ((flx_cyc & unit_mask) == unit_mask);
	assign trim_hit  = sec_tick & ctrl.trim_en & (trim_cnt == trim.interval);
	assign corr_ext  = {{24{trim.corr[7]}}, trim.corr};
	assign sec_hit   = ctrl.sec_alm_en & (sec_count == sec_alarm);
	assign flx_hit   = ctrl.flx_alm_en & (flx_cyc == flx_alarm);
	assign cap_chg   = sy_chg[SY_CAP +: NUM_CAP];
	assign cap_hit   = ctrl.cap_en & cap_chg[ctrl.cap_sel];
	assign shutdown  = (ctrl.pmode == PM_SHUTDOWN);

	// ---------------------------------------------------------------------------
	// Counters, alarms, status and register port
	// ---------------------------------------------------------------------------
	// Hardware events set status; a set in the clearing cycle wins
	always_comb begin
		st_set = '0;
		st_set[ST_SEC] = sec_hit;
		st_set[ST_FLX] = flx_hit;
		st_set[ST_PER] = unit_tick & ctrl.per_en & (per_cnt == PERIOD_LAST);
		st_set[ST_CAP] = cap_hit;
		st_set[ST_ACT +: NUM_STB] = stb_act;
		st_clr = (wr && addr == A_STAT) ? wdata[ST_W-1:0] : '0;
		irq_mask = '1;
		for (int i = 0; i < NUM_STB; i++) begin
			irq_mask[ST_ACT + i] = smp_cfg[i].irq_en;
		end
	end

	// Next state of counters and registers; software load beats counting
	always_comb begin
		next_ctrl      = ctrl;
		next_trim      = trim;
		next_sec_alarm = sec_alarm;
		next_flx_alarm = flx_alarm;
		next_stb_tgt   = stb_tgt;
		next_stb_cfg   = stb_cfg;
		next_smp_cfg   = smp_cfg;
		next_sec_div   = (ctrl.sec_en && xtal_rise) ? sec_div + 15'h1 : sec_div;
		next_sec_count = sec_tick ? sec_count + 32'h1 : sec_count;
		next_trim_cnt  = sec_tick ? (trim_hit ? 8'h0 : trim_cnt + 8'h1) : trim_cnt;
		next_flx_cyc   = flx_cyc + (flx_run ? 32'h1 : 32'h0) + (trim_hit ? corr_ext : 32'h0);
		next_per_cnt   = unit_tick ? ((per_cnt == PERIOD_LAST) ? 6'h0 : per_cnt + 6'h1) : per_cnt;
		next_cap_val   = cap_hit ? flx_cyc : cap_val;
		// One-shot absolute alarms drop their enable once fired
		if (sec_hit) begin
			next_ctrl.sec_alm_en = 1'b0;
		end
		if (flx_hit) begin
			next_ctrl.flx_alm_en = 1'b0;
		end
		next_stat = (stat & ~st_clr) | st_set;
		if (wr) begin
			case (addr)
				A_CTRL: next_ctrl = drs_ctrl_t'(wdata[$bits(drs_ctrl_t)-1:0]);
				A_SEC_CNT: begin
					next_sec_count = wdata;
					next_sec_div   = '0;
				end
				A_SEC_ALM: next_sec_alarm = wdata;
				A_FLX_ALM: next_flx_alarm = wdata;
				A_TRIM: begin
					next_trim     = drs_trim_t'(wdata[$bits(drs_trim_t)-1:0]);
					next_trim_cnt = '0;
				end
				A_FLX_CYC: begin
					next_flx_cyc = wdata;
					next_per_cnt = '0;
				end
				default: begin
					case (addr[7:4])
						PG_STB_TGT: next_stb_tgt[addr[3:2]] = wdata;
						PG_STB_CFG: next_stb_cfg[addr[3:2]] = drs_stb_cfg_t'(wdata);
						PG_SMP_CFG: next_smp_cfg[addr[3:2]] = drs_smp_cfg_t'(wdata[$bits(drs_smp_cfg_t)-1:0]);
						default: ;
					endcase
				end
			endcase
		end
		// Read data valid only in the cycle after the strobe
		next_rdata = '0;
		if (rd) begin
			case (addr)
				A_CTRL:    next_rdata = 32'(ctrl);
				A_SEC_CNT: next_rdata = sec_count;
				A_SEC_ALM: next_rdata = sec_alarm;
				A_FLX_CNT: next_rdata = flx_units;
				A_FLX_ALM: next_rdata = flx_alarm;
				A_TRIM:    next_rdata = 32'(trim);
				A_STAT:    next_rdata = 32'(stat);
				A_CAPT:    next_rdata = cap_val;
				A_FLX_CYC: next_rdata = flx_cyc;
				default: begin
					case (addr[7:4])
						PG_STB_TGT: next_rdata = stb_tgt[addr[3:2]];
						PG_STB_CFG: next_rdata = 32'(stb_cfg[addr[3:2]]);
						PG_SMP_CFG: next_rdata = 32'({smp_val[addr[3:2]], smp_cfg[addr[3:2]]});
						default:    next_rdata = '0;
					endcase
				end
			endcase
		end
		next_irq  = |(next_stat & irq_mask);
		next_wake = next_stat[ST_CAP];
	end

	// Register stage of the block state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl      <= CTRL_RST;
			trim      <= '0;
			sec_div   <= '0;
			sec_count <= '0;
			sec_alarm <= '0;
			flx_cyc   <= '0;
			flx_alarm <= '0;
			cap_val   <= '0;
			per_cnt   <= '0;
			trim_cnt  <= '0;
			stat      <= '0;
			rdata     <= '0;
			irq       <= 1'b0;
			wake      <= 1'b0;
			for (int i = 0; i < NUM_STB; i++) begin
				stb_tgt[i] <= '0;
				stb_cfg[i] <= '0;
				smp_cfg[i] <= '0;
			end
		end else begin
			ctrl      <= next_ctrl;
			trim      <= next_trim;
			sec_div   <= next_sec_div;
			sec_count <= next_sec_count;
			sec_alarm <= next_sec_alarm;
			flx_cyc   <= next_flx_cyc;
			flx_alarm <= next_flx_alarm;
			cap_val   <= next_cap_val;
			per_cnt   <= next_per_cnt;
			trim_cnt  <= next_trim_cnt;
			stat      <= next_stat;
			rdata     <= next_rdata;
			irq       <= next_irq;
			wake      <= next_wake;
			stb_tgt   <= next_stb_tgt;
			stb_cfg   <= next_stb_cfg;
			smp_cfg   <= next_smp_cfg;
		end
	end

	sec_alarm_a: assert property ((sec_hit && !wr) |=> stat[ST_SEC] && !ctrl.sec_alm_en && irq)
		else $error("seconds alarm did not flag once and disarm");
	trim_step_a: assert property ((trim_hit && !flx_run && !wr) |=> flx_cyc == $past(flx_cyc) + $past(corr_ext))
		else $error("trim correction not applied");
	sec_tick_a: assert property ((sec_tick && !wr) |=> sec_count == $past(sec_count) + 32'h1 && sec_div == 15'h0)
		else $error("seconds counter did not advance on divider wrap");
	flex_read_a: assert property ((rd && addr == A_FLX_CNT) |=> rdata == $past(flx_units))
		else $error("prescaled count read wrong");
	lf_select_a: assert property ((ctrl.flx_en && !ctrl.lf_sel && osc_rise && !xtal_rise && !trim_hit && !wr)
		|=> flx_cyc == $past(flx_cyc))
		else $error("flexible counter followed the unselected source");
	flex_alarm_a: assert property ((flx_hit && !wr) |=> stat[ST_FLX] && irq)
		else $error("flexible alarm did not flag at its source cycle");
	period_cnt_a: assert property ((unit_tick && ctrl.per_en && per_cnt == PERIOD_LAST && !wr)
		|=> stat[ST_PER] && per_cnt == 6'h0)
		else $error("periodic alarm did not flag and restart");
	sequence cap_seen_s;
		cap_hit && !wr;
	endsequence
	capture_a: assert property (cap_seen_s |=> cap_val == $past(flx_cyc) && wake && stat[ST_CAP])
		else $error("capture did not latch count and wake");
	shutdown_a: assert property (shutdown |=> !strobe_out_1 && !strobe_out_2 && !strobe_out_3)
		else $error("strobe driven in shutdown");

	// ---------------------------------------------------------------------------
	// Strobe channels with sense sampling
	// ---------------------------------------------------------------------------
	for (genvar g = 0; g < NUM_STB; g++) begin : g_stb
		drs_stb_state_t     st, next_st;
		logic [15:0]        ph, next_ph, ph_inc;
		logic [NUM_SMP-1:0] smp, next_smp;
		logic               pin, next_pin, act;

		// Pulse high for the first high cycles of each period, sample at its end
		always_comb begin
			next_st  = st;
			next_ph  = ph;
			next_smp = smp;
			act      = 1'b0;
			ph_inc   = ph + 16'h1;
			if (!stb_cfg[g].en || shutdown) begin
				next_st = STB_IDLE;
			end else begin
				case (st)
					STB_IDLE: next_st = STB_WAIT;
					STB_WAIT: begin
						if (flx_run && flx_cyc == stb_tgt[g]) begin
							next_st = STB_HIGH;
							next_ph = '0;
						end
					end
					STB_HIGH, STB_LOW: begin
						if (flx_run) begin
							if (ph == stb_cfg[g].period_m1) begin
								next_ph = '0;
								next_st = STB_HIGH;
							end else begin
								next_ph = ph_inc;
								next_st = (ph_inc < {1'b0, stb_cfg[g].high}) ? STB_HIGH : STB_LOW;
							end
						end
					end
					default: next_st = STB_IDLE;
				endcase
			end
			// Sensor lines are looked at only when the pulse ends
			if (st == STB_HIGH && next_st == STB_LOW) begin
				next_smp = sy_q[SY_SNS + g*NUM_SMP +: NUM_SMP] & smp_cfg[g].mask;
				act      = |(next_smp ^ smp);
			end
			next_pin = (next_st == STB_HIGH);
		end

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				st  <= STB_IDLE;
				ph  <= '0;
				smp <= '0;
				pin <= 1'b0;
			end else begin
				st  <= next_st;
				ph  <= next_ph;
				smp <= next_smp;
				pin <= next_pin;
			end
		end

		assign stb_pin[g] = pin;
		assign stb_act[g] = act;
		assign smp_val[g] = smp;

		sequence stb_due_s;
			st == STB_WAIT && flx_run && flx_cyc == stb_tgt[g];
		endsequence
		strobe_start_a: assert property ((stb_due_s and (stb_cfg[g].en && !shutdown && !wr)) |=> pin && ph == 16'h0)
			else $error("strobe did not start at its target count");
		activity_a: assert property ((act && !wr) |=> stat[ST_ACT + g])
			else $error("sense activity not flagged");
	end

	// Channel zero stays internal; the rest reach pins
	assign strobe_out_1 = stb_pin[1];
	assign strobe_out_2 = stb_pin[2];
	assign strobe_out_3 = stb_pin[3];

endmodule : drs_top
`default_nettype wire

// *** inc/drs_pkg.sv ***
`default_nettype none
// ---------------------------------------------------------------------------
// Shared constants and types of the dual counter block
// ---------------------------------------------------------------------------
package drs_pkg;

	// Bus shape
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// Low-frequency source rate and the seconds divider built on it
	localparam int unsigned LF_HZ        = 32768;
	localparam logic [14:0] SEC_DIV_LAST = 15'(LF_HZ - 1);

	// Periodic alarm length in prescaled units
	localparam int unsigned PERIOD_UNITS = 60;
	localparam logic [5:0]  PERIOD_LAST  = 6'(PERIOD_UNITS - 1);

	// Channel counts
	localparam int unsigned NUM_STB = 4;
	localparam int unsigned NUM_SMP = 3;
	localparam int unsigned NUM_CAP = 4;

	// Synchroniser bit layout: crystal, oscillator, capture inputs, sense inputs
	localparam int unsigned SY_XTAL = 0;
	localparam int unsigned SY_OSC  = 1;
	localparam int unsigned SY_CAP  = 2;
	localparam int unsigned SY_SNS  = SY_CAP + NUM_CAP;
	localparam int unsigned SYNC_W  = SY_SNS + NUM_STB * NUM_SMP;

	// Register offsets
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_SEC_CNT = 8'h04;
	localparam logic [7:0] A_SEC_ALM = 8'h08;
	localparam logic [7:0] A_FLX_CNT = 8'h0C;
	localparam logic [7:0] A_FLX_ALM = 8'h10;
	localparam logic [7:0] A_TRIM    = 8'h14;
	localparam logic [7:0] A_STAT    = 8'h18;
	localparam logic [7:0] A_CAPT    = 8'h1C;
	localparam logic [7:0] A_FLX_CYC = 8'h20;
	// Per-channel pages, one word per channel
	localparam logic [3:0] PG_STB_TGT = 4'h4;
	localparam logic [3:0] PG_STB_CFG = 4'h5;
	localparam logic [3:0] PG_SMP_CFG = 4'h6;

	// Status bit positions
	localparam int unsigned ST_SEC = 0;
	localparam int unsigned ST_FLX = 1;
	localparam int unsigned ST_PER = 2;
	localparam int unsigned ST_CAP = 3;
	localparam int unsigned ST_ACT = 4;
	localparam int unsigned ST_W   = ST_ACT + NUM_STB;

	// Power modes
	typedef enum logic [1:0] {
		PM_ACTIVE    = 2'h0,
		PM_FLEXI     = 2'h1,
		PM_HIBERNATE = 2'h2,
		PM_SHUTDOWN  = 2'h3
	} drs_pmode_t;

	// Control word
	typedef struct packed {
		drs_pmode_t pmode;
		logic [1:0] cap_sel;
		logic       cap_en;
		logic       trim_en;
		logic       per_en;
		logic       flx_alm_en;
		logic       sec_alm_en;
		logic [3:0] presc;
		logic       lf_sel;
		logic       flx_en;
		logic       sec_en;
	} drs_ctrl_t;
	localparam drs_ctrl_t CTRL_RST = '0;

	// Trim word: signed correction and interval in seconds
	typedef struct packed {
		logic [7:0] corr;
		logic [7:0] interval;
	} drs_trim_t;

	// Strobe channel shape
	typedef struct packed {
		logic        en;
		logic [14:0] high;
		logic [15:0] period_m1;
	} drs_stb_cfg_t;

	// Sampling setup of one channel
	typedef struct packed {
		logic       irq_en;
		logic [2:0] mask;
	} drs_smp_cfg_t;

	// Strobe channel states, Gray along idle-wait-high-low
	typedef enum logic [1:0] {
		STB_IDLE = 2'b00,
		STB_WAIT = 2'b01,
		STB_HIGH = 2'b11,
		STB_LOW  = 2'b10
	} drs_stb_state_t;

endpackage : drs_pkg
`default_nettype wire

// *** hdl/drs_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Two-flop synchroniser with change detect
// ---------------------------------------------------------------------------
module drs_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q,
	output logic      [W-1:0] chg
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// Metastability stages; s1 feeds only s2
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Change seen once per settled transition
	assign q   = s2;
	assign chg = s2 ^ s3;

	sync_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
		($past(rst_n) && $past(rst_n, 2)) |-> q == $past(d, 2))
		else $error("synchronised level does not follow input by two cycles");

endmodule : drs_sync
`default_nettype wire

// *** dv/drs_sensor_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Sensor model: answers each strobe pulse by flipping its event lines
// ---------------------------------------------------------------------------
module drs_sensor_model #(
	parameter int unsigned LAG = 1
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:1]  stb,
	input  wire logic        cap_req,
	output logic      [11:0] sense_in,
	output logic      [3:0]  capture_in
);
	logic [3:1]      prev;
	logic [3:0][3:1] rise_d;

	// Event reported LAG+2 clocks after a pulse starts; push-pull lines, never released
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev       <= '0;
			rise_d     <= '0;
			sense_in   <= '0;
			capture_in <= '0;
		end else begin
			prev          <= stb;
			rise_d        <= {rise_d[2:0], stb & ~prev};
			capture_in[0] <= capture_in[0] ^ cap_req;
			for (int c = 1; c < 4; c++) begin
				if (rise_d[LAG][c]) begin
					sense_in[3*c] <= ~sense_in[3*c];
					capture_in[c] <= ~capture_in[c];
				end
			end
		end
	end
endmodule : drs_sensor_model
`default_nettype wire

// *** dv/drs_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s expected %0h seen %0h", nm, (e), (g)); end end
module drs_top_test;
	import drs_pkg::*;
	// LF pins run faster than real, still two clocks per level or more
	localparam int LF_HALF = 4;
	localparam int LIMIT   = 20000;
	typedef struct packed {logic [7:0] wa; logic [7:0] ra; logic [31:0] wd; logic [31:0] ex;} drs_row_t;
	localparam drs_row_t ROWS [12] = '{
		'{A_CTRL, A_CTRL, 32'h0000_7C7E, 32'h0000_7C7E}, '{A_CTRL, A_CTRL, 32'h0, 32'h0},
		'{A_SEC_CNT, A_SEC_CNT, 32'h1234_5678, 32'h1234_5678}, '{A_TRIM, A_TRIM, 32'hFE05, 32'hFE05},
		'{A_FLX_ALM, A_FLX_ALM, 32'h0ABC, 32'h0ABC}, '{A_FLX_CYC, A_FLX_CYC, 32'h1000, 32'h1000},
		'{A_FLX_CNT, A_FLX_CNT, 32'h5555, 32'h1000}, '{8'h30, 8'h30, 32'hFFFF_FFFF, 32'h0},
		'{8'h4B, 8'h48, 32'h0123, 32'h0123}, '{8'h64, 8'h64, 32'hFF, 32'h0F},
		'{A_STAT, A_STAT, 32'hFF, 32'h0}, '{A_CAPT, A_CAPT, 32'hFFFF, 32'h0}};
	logic              clk     = 1'b0;
	logic              rst_n   = 1'b0;
	logic [ADDR_W-1:0] addr    = '0;
	logic [DATA_W-1:0] wdata   = '0;
	logic              wr      = 1'b0;
	logic              rd      = 1'b0;
	logic              lf_xtal = 1'b0;
	logic              lf_osc  = 1'b0;
	logic              cap_req = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic [3:0]        cap;
	logic [11:0]       sense;
	logic              s1, s2, s3, irq, wake;
	logic [DATA_W-1:0] v;
	logic [9:0]        pat;
	int                num_errors = 0;
	int                n_tests    = 0;
	int                cycles     = 0;

	always #25 clk = ~clk;

	drs_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.lf_crystal_clock(lf_xtal), .lf_internal_osc(lf_osc), .capture_in(cap), .sense_in(sense),
		.strobe_out_1(s1), .strobe_out_2(s2), .strobe_out_3(s3), .irq(irq), .wake(wake));
	drs_sensor_model #(.LAG(1)) sensor (.clk(clk), .rst_n(rst_n), .stb({s3, s2, s1}), .cap_req(cap_req),
		.sense_in(sense), .capture_in(cap));

	// ---------------------------------------------------------------------------
	// Bus and pin tasks
	// ---------------------------------------------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg
	task automatic ticks(input bit osc, input int n);
		repeat (n) begin
			@(posedge clk);
			if (osc) lf_osc <= 1'b1;
			else lf_xtal <= 1'b1;
			repeat (LF_HALF) @(posedge clk);
			lf_osc  <= 1'b0;
			lf_xtal <= 1'b0;
			repeat (LF_HALF - 1) @(posedge clk);
		end
	endtask : ticks
	task automatic chk_stat(input string nm, input int b, input logic e);
		rd_reg(A_STAT, v);
		`CHK(nm, e, v[b])
	endtask : chk_stat
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			num_errors++;
			$display("wrong value run length expected %0d seen %0d", LIMIT - 1, cycles);
			print_verdict();
		end
	end

	// ---------------------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------------------
	initial begin
		@(posedge clk);
		@(negedge clk);
		`CHK("outputs in reset", 37'h0, {rdata, s3, s2, s1, irq, wake})
		@(posedge clk);
		rst_n <= 1'b1;
		rd_reg(A_CTRL, v);
		`CHK("ctrl reset", 32'h0, v)
		foreach (ROWS[i]) begin
			wr_reg(ROWS[i].wa, ROWS[i].wd);
			rd_reg(ROWS[i].ra, v);
			`CHK("register", ROWS[i].ex, v)
		end
		@(posedge clk);
		#1;
		`CHK("rdata after read", 32'h0, rdata)
		$display("done: register table");
		for (int p = 0; p < 16; p++) begin
			wr_reg(A_CTRL, 32'(p) << 3);
			wr_reg(A_FLX_CYC, 32'h0001_2345);
			rd_reg(A_FLX_CNT, v);
			`CHK("prescaled count", 32'h0001_2345 >> p, v)
		end
		$display("done: prescale");
		wr_reg(A_CTRL, 32'h6);
		wr_reg(A_FLX_CYC, 32'h0);
		ticks(0, 3);
		ticks(1, 5);
		rd_reg(A_FLX_CYC, v);
		`CHK("cycles on osc", 32'h5, v)
		wr_reg(A_CTRL, 32'h2);
		wr_reg(A_FLX_CYC, 32'h0);
		ticks(1, 4);
		ticks(0, 2);
		rd_reg(A_FLX_CYC, v);
		`CHK("cycles on crystal", 32'h2, v)
		$display("done: source select");
		wr_reg(A_SEC_CNT, 32'h7);
		wr_reg(A_SEC_ALM, 32'h7);
		wr_reg(A_CTRL, 32'h81);
		chk_stat("seconds alarm", ST_SEC, 1'b1);
		rd_reg(A_CTRL, v);
		`CHK("seconds alarm enable", 32'h1, v)
		wr_reg(A_STAT, 32'h1);
		chk_stat("seconds alarm again", ST_SEC, 1'b0);
		$display("done: seconds alarm");
		wr_reg(A_FLX_ALM, 32'h5);
		wr_reg(A_FLX_CYC, 32'h0);
		wr_reg(A_CTRL, 32'h102);
		ticks(0, 4);
		chk_stat("flex alarm early", ST_FLX, 1'b0);
		ticks(0, 1);
		chk_stat("flex alarm", ST_FLX, 1'b1);
		`CHK("irq on alarm", 1'b1, irq)
		wr_reg(A_STAT, 32'h2);
		@(posedge clk);
		#1;
		`CHK("irq cleared", 1'b0, irq)
		$display("done: flex alarm");
		wr_reg(A_CTRL, 32'h202);
		wr_reg(A_FLX_CYC, 32'h0);
		ticks(0, PERIOD_UNITS - 1);
		chk_stat("periodic early", ST_PER, 1'b0);
		ticks(0, 1);
		chk_stat("periodic", ST_PER, 1'b1);
		wr_reg(A_CTRL, 32'h2);
		wr_reg(A_STAT, 32'hFF);
		$display("done: periodic alarm");
		for (int pm = 0; pm < 4; pm++) begin
			wr_reg(8'h54, 32'h0002_0003);
			wr_reg(A_CTRL, (32'(pm) << 14) | 32'h2);
			wr_reg(A_FLX_CYC, 32'h0);
			wr_reg(8'h44, 32'h3);
			wr_reg(8'h64, (pm == 1) ? 32'h1 : 32'h9);
			wr_reg(8'h54, 32'h8002_0003);
			for (int t = 0; t < 10; t++) begin
				ticks(0, 1);
				#1;
				pat[t] = s1 | s2 | s3;
			end
			`CHK("strobe before target", 2'b00, pat[1:0])
			`CHK("strobe high ticks", (pm == 3) ? 0 : 4, $countones(pat))
			`CHK("strobe pulses", (pm == 3) ? 0 : 2, $countones(pat & ~(pat << 1)))
			chk_stat("activity", ST_ACT + 1, pm != 3);
			`CHK("activity irq", pm == 0 || pm == 2, irq)
			wr_reg(A_STAT, 32'hFF);
		end
		wr_reg(8'h54, 32'h0);
		wr_reg(A_CTRL, 32'h2);
		// Each remaining channel must reach its own pin and no other
		for (int c = 2; c < 4; c++) begin
			wr_reg(A_FLX_CYC, 32'h0);
			wr_reg(8'(8'h40 + 4 * c), 32'h1);
			wr_reg(8'(8'h50 + 4 * c), 32'h8001_0001);
			ticks(0, 2);
			`CHK("strobe pin map", 3'b1 << (c - 1), {s3, s2, s1})
			wr_reg(8'(8'h50 + 4 * c), 32'h0);
		end
		$display("done: strobes");
		wr_reg(A_CTRL, 32'h802);
		wr_reg(A_FLX_CYC, 32'h10);
		cap_req <= 1'b1;
		@(posedge clk);
		cap_req <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		`CHK("wake", 1'b1, wake)
		`CHK("capture irq", 1'b1, irq)
		rd_reg(A_CAPT, v);
		`CHK("capture value", 32'h10, v)
		wr_reg(A_STAT, 32'h8);
		repeat (8) @(posedge clk);
		chk_stat("capture once", ST_CAP, 1'b0);
		wr_reg(A_CTRL, 32'h1802);
		cap_req <= 1'b1;
		@(posedge clk);
		cap_req <= 1'b0;
		repeat (8) @(posedge clk);
		chk_stat("unselected capture", ST_CAP, 1'b0);
		$display("done: capture");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(A_CTRL, v);
		`CHK("ctrl after reset", 32'h0, v)
		$display("done: second reset");
		print_verdict();
	end
endmodule : drs_top_test
`undef CHK
`default_nettype wire
